// [ext_ctrl_pkg.sv]
// constants shared by the extension control register bank
package ext_ctrl_pkg;
	// ****************************************
	// register indices and byte addresses
	// ****************************************
	localparam logic [7:0] IDX_FIFO_CTRL = 8'h17; // write fifo control index
	localparam logic [7:0] IDX_MISC_CTRL = 8'h1e; // misc chip control index
	localparam logic [7:0] IDX_CHIP_INFO = 8'h1f; // chip information index
	localparam logic [7:0] IDX_IRQ_STAT  = 8'h40; // event status index
	localparam logic [7:0] IDX_IRQ_MASK  = 8'h41; // event mask index
	localparam int         ADDR_SHIFT    = 2;     // byte address = index * 4

	// ****************************************
	// field positions
	// ****************************************
	localparam int FIFO_FLUSH_BIT  = 7; // flush / empty bit
	localparam int MISC_BYPASS     = 0; // synthesizer bypass
	localparam int MISC_LOWPWR     = 1; // low-power dynamic
	localparam int MISC_SUSPEND    = 2; // suspend
	localparam int MISC_CORE5V     = 3; // input threshold select
	localparam int MISC_LED        = 4; // drive led on irq12
	localparam int MISC_TRI7       = 5; // three-state data bit 7
	localparam int MISC_DMA        = 6; // dma pin configuration
	localparam int MISC_RING       = 7; // irq15 ring indicate
	localparam int INFO_DUAL_BIT   = 5; // dual socket flag
	localparam int INFO_REV_LSB    = 1; // revision field low bit

	// ****************************************
	// reset values and fixed codes
	// ****************************************
	localparam logic [6:0] SCRATCH_RST  = 7'h00; // scratchpad reset
	localparam logic [7:0] MISC_RST     = 8'h02; // low-power set at reset
	localparam logic [1:0] ID_FIRST     = 2'h3;  // first read pattern
	localparam logic [1:0] ID_SECOND    = 2'h0;  // second read pattern
	localparam logic [2:0] EV_WIDTH     = 3'h3;  // number of event bits
	localparam int         EV_FLUSHED   = 0;     // flush bit written
	localparam int         EV_RING      = 1;     // ring edge seen
	localparam int         EV_SPKR      = 2;     // led activity start

	// ****************************************
	// clock timing
	// ****************************************
	localparam int CLK_MHZ   = 100;                 // system clock rate
	localparam int SYN_MUL   = 7;                   // synthesizer multiply
	localparam int SYN_DIV   = 4;                   // synthesizer divide
	localparam int IDLE_NS   = 80;                  // inactivity before stop
	localparam int IDLE_CYC  = (IDLE_NS * CLK_MHZ + 999) / 1000; // rounded up
endpackage

// [ext_ctrl_regs.sv]
// extension control register bank: fifo control, misc control, chip info
//
// Behaviour
// R1 - writing one to flush empties write fifo
// R2 - flush bit reads one when fifo empty
// R3 - writing zero to flush does nothing
// R4 - power loss, removal, supply off empty fifo
// R5 - seven scratchpad bits, reset to zero
// R6 - software checks empty before timing changes
// R7 - internal clock input times 7/4 unless bypassed
// R8 - low-power bit stops idle clock, default set
// R9 - suspend stops synthesizer, blocks socket access
// R10 - suspend with aen high gates isa inputs
// R11 - led mode drives irq12 open-drain from speaker
// R12 - tri-state bit 7 at floppy addresses
// R13 - dma bit reconfigures irq9, irq10, vpp valid
// R14 - ring mode signals irq15 on status fall
// R15 - id bits read 11 then 00 alternating
// R16 - bit 5 shows dual or single socket
// R17 - bits 4:1 hold fixed revision code
// R18 - after flush, next read shows empty
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
module ext_ctrl_regs #(
	parameter int         DEPTH_W  = 3,     // log2 of fifo depth
	parameter logic       DUAL     = 1'b1,  // dual-socket build
	parameter logic [3:0] REVISION = 4'h5   // arbitrary revision value
) (
	input  wire logic        CLOCK,          // system clock
	input  wire logic        RESET,          // async reset, high
	input  wire logic        PSEL,           // apb select
	input  wire logic        PENABLE,        // apb access phase
	input  wire logic        PWRITE,         // apb direction
	input  wire logic [11:0] PADDR,          // apb byte address
	input  wire logic [31:0] PWDATA,         // apb write data
	output logic      [31:0] PRDATA,         // apb read data
	output logic             PREADY,         // apb ready
	output logic             PSLVERR,        // apb error
	input  wire logic        FIFO_PUSH,      // host write enters fifo
	input  wire logic        FIFO_POP,       // socket drains an entry
	output logic             FIFO_EMPTY,     // fifo holds nothing
	output logic             FIFO_FULL,      // fifo cannot take more
	input  wire logic        POWER_GOOD_N_LOW, // power-good input low
	input  wire logic        CARD_PRESENT,   // card detect
	input  wire logic        SUPPLY_EN,      // socket supply enable bit
	input  wire logic        CARD_BUSY,      // card activity in progress
	input  wire logic        AEN,            // isa address enable
	input  wire logic        SPKR_ACTIVE,    // card speaker signal on
	input  wire logic        SPKR_AS_LED,    // speaker-as-led select
	input  wire logic        STSCHG,         // card status change line
	input  wire logic        IRQ12_REQ,      // normal irq12 request
	input  wire logic        IRQ15_REQ,      // normal irq15 request
	input  wire logic        IO_READ,        // socket io read cycle
	input  wire logic [15:0] IO_ADDR,        // socket io address
	output logic             IRQ12_O,        // irq12 output value
	output logic             IRQ12_OE,       // irq12 drive enable
	output logic             IRQ15_O,        // irq15 output
	output logic             D7_OE,          // host data bit 7 enable
	output logic             ISA_IN_EN,      // isa input buffers on
	output logic             SOCKET_EN,      // socket access allowed
	output logic             SYN_RUN,        // synthesizer running
	output logic             SYN_BYPASS,     // internal clock = input
	output logic [2:0]       SYN_MUL_O,      // synthesizer multiplier
	output logic [2:0]       SYN_DIV_O,      // synthesizer divider
	output logic             INT_CLK_RUN,    // internal clock enable
	output logic             CORE_5V,        // input threshold select
	output logic             DMA_MODE,       // dma pin configuration
	output logic             IRQ             // event interrupt, level
);
	// ****************************************
	// address decode
	// ****************************************
	wire [9:0] idx      = PADDR[11:ext_ctrl_pkg::ADDR_SHIFT]; // word index
	wire       aligned  = PADDR[1:0] == 2'h0; // word aligned only
	wire       acc      = PSEL && PENABLE;    // access phase
	wire       hit_fifo = idx == {2'h0, ext_ctrl_pkg::IDX_FIFO_CTRL};
	wire       hit_misc = idx == {2'h0, ext_ctrl_pkg::IDX_MISC_CTRL};
	wire       hit_info = idx == {2'h0, ext_ctrl_pkg::IDX_CHIP_INFO};
	wire       hit_stat = idx == {2'h0, ext_ctrl_pkg::IDX_IRQ_STAT};
	wire       hit_mask = idx == {2'h0, ext_ctrl_pkg::IDX_IRQ_MASK};
	wire       mapped   = aligned &&
		(hit_fifo || hit_misc || hit_info || hit_stat || hit_mask);
	// single-cycle access: ready lags the access phase by one edge
	wire       done     = acc && !PREADY;
	wire       wr       = done && PWRITE && mapped;
	wire       rd       = done && !PWRITE && mapped;

	// ****************************************
	// state
	// ****************************************
	logic [DEPTH_W:0] count_q;   // fifo occupancy
	logic [DEPTH_W:0] count_d;   // next occupancy
	logic [6:0]       scratch_q; // scratchpad bits
	logic [7:0]       misc_q;    // misc chip control
	logic             id_q;      // 1: next info read shows 11
	logic [2:0]       stat_q;    // sticky events
	logic [2:0]       mask_q;    // event mask
	logic             sts_q;     // previous status-change level
	logic             spk_q;     // previous led drive level
	logic [7:0]       idle_q;    // inactivity counter

	// ****************************************
	// write fifo occupancy
	// ****************************************
	wire full_w  = count_q[DEPTH_W];               // top bit means full
	wire empty_w = count_q == '0;
	wire push    = FIFO_PUSH && !full_w && SOCKET_EN;
	wire pop     = FIFO_POP && !empty_w;
	wire flush_w = wr && hit_fifo &&
		PWDATA[ext_ctrl_pkg::FIFO_FLUSH_BIT];      // R1 R3
	wire drop    = POWER_GOOD_N_LOW || !CARD_PRESENT || !SUPPLY_EN; // R4
	always_comb
	begin
		count_d = count_q;
		// flush beats a same-cycle push, so the next read shows empty
		if (flush_w || drop)
			count_d = '0;                              // R1 R4 R18
		else if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	// ****************************************
	// pin functions
	// ****************************************
	wire led_mode  = misc_q[ext_ctrl_pkg::MISC_LED];
	wire ring_mode = misc_q[ext_ctrl_pkg::MISC_RING];
	wire suspend   = misc_q[ext_ctrl_pkg::MISC_SUSPEND];
	wire led_on    = SPKR_ACTIVE && SPKR_AS_LED;       // R11
	wire ring_edge = sts_q && !STSCHG;                 // R14
	wire floppy    = IO_ADDR == 16'h03f7 || IO_ADDR == 16'h0377;
	wire idle_done = idle_q >= 8'(ext_ctrl_pkg::IDLE_CYC);
	wire [2:0] ev  = {led_on && !spk_q && led_mode,
		ring_edge && ring_mode, flush_w};

	// ****************************************
	// read mux
	// ****************************************
	wire [7:0] info_w = {id_q ? ext_ctrl_pkg::ID_FIRST :
		ext_ctrl_pkg::ID_SECOND, DUAL, REVISION, 1'b0}; // R15 R16 R17
	wire [7:0] rdata  =
		hit_fifo ? {empty_w, scratch_q} :               // R2
		hit_misc ? misc_q :
		hit_info ? info_w :
		hit_stat ? {5'h00, stat_q} :
		hit_mask ? {5'h00, mask_q} : 8'h00;

	// ****************************************
	// apb answer
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= 32'h0;
		end
		else
		begin
			PREADY  <= done;
			PSLVERR <= done && !mapped;   // unmapped answers error
			PRDATA  <= rd ? {24'h0, rdata} : 32'h0;
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			scratch_q <= ext_ctrl_pkg::SCRATCH_RST; // R5
			misc_q    <= ext_ctrl_pkg::MISC_RST;    // R8
			mask_q    <= 3'h0;
		end
		else if (wr)
		begin
			if (hit_fifo)
				scratch_q <= PWDATA[6:0];        // R5
			if (hit_misc)
				misc_q <= PWDATA[7:0];
			if (hit_mask)
				mask_q <= PWDATA[2:0];
		end
	end

	// ****************************************
	// fifo count and info toggle
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			count_q <= '0;
			id_q    <= 1'b1;
		end
		else
		begin
			count_q <= count_d;
			if (wr && hit_info)
				id_q <= 1'b1;                    // R15
			else if (rd && hit_info)
				id_q <= !id_q;                   // R15
		end
	end

	// ****************************************
	// sticky events, set wins over clear
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			stat_q <= 3'h0;
			sts_q  <= 1'b1;
			spk_q  <= 1'b0;
		end
		else
		begin
			stat_q <= (stat_q & ~((wr && hit_stat) ? PWDATA[2:0] : 3'h0))
				| ev;
			sts_q  <= STSCHG;
			spk_q  <= led_on;
		end
	end

	// ****************************************
	// inactivity counter for dynamic clock stop
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			idle_q <= 8'h00;
		else if (CARD_BUSY || PSEL || !empty_w)
			idle_q <= 8'h00;
		else if (!idle_done)
			idle_q <= idle_q + 8'h01;
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			FIFO_EMPTY  <= 1'b1;
			FIFO_FULL   <= 1'b0;
			IRQ12_O     <= 1'b0;
			IRQ12_OE    <= 1'b0;
			IRQ15_O     <= 1'b0;
			D7_OE       <= 1'b0;
			ISA_IN_EN   <= 1'b1;
			SOCKET_EN   <= 1'b1;
			SYN_RUN     <= 1'b1;
			SYN_BYPASS  <= 1'b0;
			SYN_MUL_O   <= 3'h7;
			SYN_DIV_O   <= 3'h4;
			INT_CLK_RUN <= 1'b1;
			CORE_5V     <= 1'b0;
			DMA_MODE    <= 1'b0;
			IRQ         <= 1'b0;
		end
		else
		begin
			FIFO_EMPTY  <= count_d == '0;
			FIFO_FULL   <= count_d[DEPTH_W];
			// open drain: drive low while led lit, else pass irq12
			IRQ12_O     <= led_mode ? 1'b0 : IRQ12_REQ;      // R11
			IRQ12_OE    <= led_mode ? led_on : 1'b1;         // R11
			IRQ15_O     <= ring_mode ? ring_edge : IRQ15_REQ; // R14
			D7_OE       <= IO_READ &&
				!(misc_q[ext_ctrl_pkg::MISC_TRI7] && floppy); // R12
			ISA_IN_EN   <= !(suspend && AEN);                // R10
			SOCKET_EN   <= !suspend;                         // R9
			SYN_RUN     <= !suspend &&
				!misc_q[ext_ctrl_pkg::MISC_BYPASS];           // R9
			SYN_BYPASS  <= misc_q[ext_ctrl_pkg::MISC_BYPASS]; // R7
			SYN_MUL_O   <= misc_q[ext_ctrl_pkg::MISC_BYPASS] ? 3'h1 :
				3'(ext_ctrl_pkg::SYN_MUL);                    // R7
			SYN_DIV_O   <= misc_q[ext_ctrl_pkg::MISC_BYPASS] ? 3'h1 :
				3'(ext_ctrl_pkg::SYN_DIV);                    // R7
			INT_CLK_RUN <= !suspend && !(misc_q[ext_ctrl_pkg::MISC_LOWPWR]
				&& idle_done);                                // R8 R9
			CORE_5V     <= misc_q[ext_ctrl_pkg::MISC_CORE5V];
			DMA_MODE    <= misc_q[ext_ctrl_pkg::MISC_DMA];   // R13
			IRQ         <= |(((stat_q & ~((wr && hit_stat) ? PWDATA[2:0]
				: 3'h0)) | ev) & mask_q);
		end
	end
endmodule // ext_ctrl_regs

// [ext_ctrl_regs_asserts.sv]
// port-level assertions for the extension control register bank
`timescale 1ns/10ps
module ext_ctrl_chk (
	input wire logic        CLOCK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        FIFO_EMPTY,
	input wire logic        POWER_GOOD_N_LOW,
	input wire logic        CARD_PRESENT,
	input wire logic        SUPPLY_EN,
	input wire logic        AEN,
	input wire logic        IRQ12_REQ,
	input wire logic        IO_READ,
	input wire logic [15:0] IO_ADDR,
	input wire logic        IRQ12_O,
	input wire logic        IRQ12_OE,
	input wire logic        D7_OE,
	input wire logic        ISA_IN_EN,
	input wire logic        SOCKET_EN,
	input wire logic        SYN_RUN,
	input wire logic        SYN_BYPASS,
	input wire logic [2:0]  SYN_MUL_O,
	input wire logic [2:0]  SYN_DIV_O,
	input wire logic        INT_CLK_RUN
);
	// ****************************************
	// helpers and properties
	// ****************************************
	default clocking @(posedge CLOCK);
	endclocking
	default disable iff (RESET);
	// flush request taken at this edge
	wire flush_wr = PSEL & PENABLE & PWRITE & ~PREADY & PWDATA[7]
		& (PADDR == 12'h05c);
	// any cause that drops the queue
	wire drop = POWER_GOOD_N_LOW | ~CARD_PRESENT | ~SUPPLY_EN;
	// floppy change addresses
	wire flop = (IO_ADDR == 16'h03f7) | (IO_ADDR == 16'h0377);

	a_flush_empty: assert property (flush_wr |-> ##[1:2] FIFO_EMPTY)
		else $error("flush left fifo occupied");
	a_drop_empty: assert property (drop [*3] |-> FIFO_EMPTY)
		else $error("fifo kept data after drop");
	a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
		else $error("apb answer late");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready stood too long");
	a_err_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
		else $error("refused access returned data");
	a_upper_zero: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_syn_ratio: assert property (SYN_BYPASS ?
		(SYN_MUL_O == 3'h1 && SYN_DIV_O == 3'h1) :
		(SYN_MUL_O == 3'h7 && SYN_DIV_O == 3'h4))
		else $error("synthesizer ratio wrong");
	a_suspend_stop: assert property (!SOCKET_EN |-> !SYN_RUN && !INT_CLK_RUN)
		else $error("suspend left clock or socket on");
	a_isa_gate: assert property (ISA_IN_EN == (SOCKET_EN || !$past(AEN)))
		else $error("isa input gating wrong");
	a_irq12_src: assert property (IRQ12_O |-> IRQ12_OE && $past(IRQ12_REQ))
		else $error("irq12 driven without cause");
	a_irq12_drain: assert property (!IRQ12_OE |-> !IRQ12_O)
		else $error("irq12 value while released");
	a_d7_cause: assert property (D7_OE |-> $past(IO_READ))
		else $error("bit 7 driven outside read");
	a_d7_plain: assert property (!$past(RESET) && $past(IO_READ)
		&& !$past(flop) |-> D7_OE)
		else $error("bit 7 released at plain address");
	c_flush: cover property (flush_wr);
	c_suspend: cover property (!SYN_RUN && !ISA_IN_EN);
	c_led: cover property (IRQ12_OE && !IRQ12_O);
	c_refused: cover property (PREADY && PSLVERR);
endmodule // ext_ctrl_chk

bind ext_ctrl_regs ext_ctrl_chk chk_u (.CLOCK, .RESET, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .FIFO_EMPTY,
	.POWER_GOOD_N_LOW, .CARD_PRESENT, .SUPPLY_EN, .AEN, .IRQ12_REQ,
	.IO_READ, .IO_ADDR, .IRQ12_O, .IRQ12_OE, .D7_OE, .ISA_IN_EN,
	.SOCKET_EN, .SYN_RUN, .SYN_BYPASS, .SYN_MUL_O, .SYN_DIV_O,
	.INT_CLK_RUN);

// [ext_sock_model.sv]
// socket side model: drains the posted write fifo
`timescale 1ns/10ps
module ext_sock_model (
	input  wire logic clock,      // system clock
	input  wire logic reset,      // async reset, high
	input  wire logic stall,      // socket holds off draining
	input  wire logic fifo_empty, // nothing queued
	output logic      fifo_pop    // take one entry
);
	logic half_q; // slow socket: one entry every other cycle
	// drain process, stops popping one edge after stall rises
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			half_q   <= 1'h0;
			fifo_pop <= 1'h0;
		end
		else
		begin
			half_q   <= ~half_q;
			fifo_pop <= ~stall & ~fifo_empty & half_q;
		end
	end
endmodule // ext_sock_model

// [ext_ctrl_regs_tb_top.sv]
// self-checking bench for the extension control register bank
`timescale 1ns/10ps
module ext_ctrl_regs_tb_top;
	localparam logic        DUAL_P = 1'h1; // dual-socket build
	localparam logic [3:0]  REV_P  = 4'h9; // arbitrary revision value
	localparam logic [11:0] A_FIFO = {2'h0, ext_ctrl_pkg::IDX_FIFO_CTRL, 2'h0};
	localparam logic [11:0] A_MISC = {2'h0, ext_ctrl_pkg::IDX_MISC_CTRL, 2'h0};
	localparam logic [11:0] A_INFO = {2'h0, ext_ctrl_pkg::IDX_CHIP_INFO, 2'h0};
	localparam logic [11:0] A_STAT = {2'h0, ext_ctrl_pkg::IDX_IRQ_STAT, 2'h0};
	localparam logic [11:0] A_MASK = {2'h0, ext_ctrl_pkg::IDX_IRQ_MASK, 2'h0};
	localparam logic [7:0]  INFO = {2'h0, DUAL_P, REV_P, 1'h0}; // id bits clear
	logic CLOCK = 1'h0, RESET = 1'h1, PSEL = 1'h0, PENABLE = 1'h0;
	logic PWRITE = 1'h0, FIFO_PUSH = 1'h0, POWER_GOOD_N_LOW = 1'h0;
	logic CARD_PRESENT = 1'h1, SUPPLY_EN = 1'h1, CARD_BUSY = 1'h0, AEN = 1'h0;
	logic SPKR_ACTIVE = 1'h0, SPKR_AS_LED = 1'h0, STSCHG = 1'h1;
	logic IRQ12_REQ = 1'h0, IRQ15_REQ = 1'h0, IO_READ = 1'h0, stall = 1'h1;
	logic [11:0] PADDR = 12'h0;
	logic [31:0] PWDATA = 32'h0, PRDATA;
	logic [15:0] IO_ADDR = 16'h0;
	logic [2:0]  SYN_MUL_O, SYN_DIV_O;
	logic PREADY, PSLVERR, FIFO_EMPTY, FIFO_FULL, IRQ12_O, IRQ12_OE, IRQ15_O;
	logic D7_OE, ISA_IN_EN, SOCKET_EN, SYN_RUN, SYN_BYPASS, INT_CLK_RUN;
	logic CORE_5V, DMA_MODE, IRQ, FIFO_POP;
	int          error_cnt = 0, compares = 0, k, n;
	logic [32:0] exp_q[$]; // expected {error, read data}, oldest first
	logic [32:0] got;      // note taken off the queue
	logic [6:0]  sc;       // scratchpad value
	logic [7:0]  m;        // random misc value

	ext_ctrl_regs #(.DEPTH_W(3), .DUAL(DUAL_P), .REVISION(REV_P)) dut_u (.*);
	ext_sock_model sock_u (.clock(CLOCK), .reset(RESET), .stall(stall),
		.fifo_empty(FIFO_EMPTY), .fifo_pop(FIFO_POP));

	always #5 CLOCK = ~CLOCK;

	// ****************************************
	// tasks
	// ****************************************
	task finish_test;
	begin
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task chk(input logic ok);
	begin
		compares++;
		if (ok !== 1'h1)
		begin
			error_cnt++;
			$display("ERROR %0t output mismatch", $time);
		end
	end
	endtask
	// one apb transfer; a read leaves its expectation on the queue
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
	begin
		if (!w)
			exp_q.push_back(e);
		PSEL <= 1'h1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'h1;
		do @(posedge CLOCK); while (PREADY !== 1'h1);
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CLOCK);
	end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'h1, a, {24'h0, d}, 33'h0);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] d);
		apb(1'h0, a, 32'h0, {25'h0, d});
	endtask
	// read monitor: compares each answer with the oldest note
	always @(posedge CLOCK)
	begin
		if (PREADY === 1'h1 && PWRITE === 1'h0)
		begin
			got = exp_q.pop_front();
			compares++;
			if ({PSLVERR, PRDATA} !== got)
			begin
				error_cnt++;
				$display("ERROR %0t read %h expected %h", $time, PRDATA, got);
			end
		end
	end
	// watchdog, far beyond the sequence length
	initial
	begin
		repeat (20000) @(posedge CLOCK);
		error_cnt++;
		finish_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		void'($urandom(49));
		repeat (10) @(posedge CLOCK);
		RESET <= 1'h0;
		@(posedge CLOCK);
		rd(A_MISC, ext_ctrl_pkg::MISC_RST);
		rd(A_FIFO, 8'h80);
		rd(A_INFO, {2'h3, INFO[5:0]});
		rd(A_INFO, INFO);
		rd(A_INFO, {2'h3, INFO[5:0]});
		wr(A_INFO, 8'h00);
		rd(A_INFO, {2'h3, INFO[5:0]});
		apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0});
		sc = $urandom;
		wr(A_FIFO, {1'h0, sc});
		FIFO_PUSH <= 1'h1;
		repeat (10) @(posedge CLOCK);
		FIFO_PUSH <= 1'h0;
		chk(FIFO_FULL === 1'h1);
		wr(A_FIFO, {1'h0, sc});
		rd(A_FIFO, {1'h0, sc});
		wr(A_MASK, 8'h01);
		wr(A_STAT, 8'h07);
		chk(IRQ === 1'h0);
		wr(A_FIFO, {1'h1, sc});
		rd(A_FIFO, {1'h1, sc});
		chk(IRQ === 1'h1);
		wr(A_MASK, 8'h00);
		chk(IRQ === 1'h0);
		wr(A_MASK, 8'h01);
		wr(A_STAT, 8'h01);
		chk(IRQ === 1'h0);
		// each drop cause in turn, then a draining socket
		for (k = 0; k < 4; k++)
		begin
			FIFO_PUSH <= 1'h1;
			@(posedge CLOCK);
			FIFO_PUSH <= 1'h0;
			POWER_GOOD_N_LOW <= (k == 0);
			CARD_PRESENT <= (k != 1);
			SUPPLY_EN <= (k != 2);
			stall <= (k != 3);
			repeat (6) @(posedge CLOCK);
			POWER_GOOD_N_LOW <= 1'h0;
			CARD_PRESENT <= 1'h1;
			SUPPLY_EN <= 1'h1;
			rd(A_FIFO, {1'h1, sc});
		end
		m = $urandom;
		m[ext_ctrl_pkg::MISC_SUSPEND] = 1'h0;
		wr(A_MISC, m);
		rd(A_MISC, m);
		chk(SYN_BYPASS === m[0] && DMA_MODE === m[6] && CORE_5V === m[3]);
		wr(A_MISC, 8'h04);
		AEN <= 1'h1;
		repeat (2) @(posedge CLOCK);
		chk(ISA_IN_EN === 1'h0 && SOCKET_EN === 1'h0);
		AEN <= 1'h0;
		repeat (2) @(posedge CLOCK);
		chk(ISA_IN_EN === 1'h1);
		wr(A_MISC, 8'h02);
		repeat (12) @(posedge CLOCK);
		chk(INT_CLK_RUN === 1'h0);
		CARD_BUSY <= 1'h1;
		// idle flag clears one edge late, the output one edge after that
		repeat (3) @(posedge CLOCK);
		chk(INT_CLK_RUN === 1'h1);
		wr(A_MISC, 8'hb0);
		IO_READ <= 1'h1;
		for (k = 0; k < 3; k++)
		begin
			IO_ADDR <= (k == 0) ? 16'h03f7 : (k == 1) ? 16'h0377 : 16'h03f6;
			repeat (2) @(posedge CLOCK);
			chk(D7_OE === (k == 2));
		end
		SPKR_ACTIVE <= 1'h1;
		SPKR_AS_LED <= 1'h1;
		IRQ12_REQ <= 1'h1;
		STSCHG <= 1'h0;
		n = 0;
		repeat (4)
		begin
			@(posedge CLOCK);
			if (IRQ15_O === 1'h1)
				n++;
		end
		chk(n == 1);
		chk(IRQ12_OE === 1'h1 && IRQ12_O === 1'h0);
		finish_test();
	end
endmodule // ext_ctrl_regs_tb_top
